// ---- audio_gain_path.sv ----
// record and playback gain, mute ramp, sidetone and high-pass path
`timescale 1ns/1ps
module audio_gain_path
    import audio_path_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire stereo_t rec_in,
    input wire logic rec_in_valid,
    output logic rec_in_ready,
    output stereo_t rec_out,
    output logic rec_out_valid,
    input wire logic rec_out_ready,
    input wire stereo_t play_in,
    input wire logic play_in_valid,
    output logic play_in_ready,
    output stereo_t play_out,
    output logic play_out_valid,
    input wire logic play_out_ready
);
    // ************************************************************
    // control registers
    // ************************************************************
    logic mute_q, unmute_ramp_q, speed_q, stopband_q, hpf_on_q;
    side_src_t side_src_q [2];
    logic [1:0] corner_q;
    logic inv_q [2], rec_on_q [2], play_on_q [2];
    logic [7:0] rec_pend_q [2], play_pend_q [2];
    logic rec_commit_q, play_commit_q, wr_gain_rec, wr_gain_play;

    assign wr_gain_rec = reg_wr && (reg_addr == REC_GAIN_L_IDX || reg_addr == REC_GAIN_R_IDX);
    assign wr_gain_play = reg_wr
        && (reg_addr == PLAY_GAIN_L_IDX || reg_addr == PLAY_GAIN_R_IDX);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mute_q <= MUTE_RST;
            unmute_ramp_q <= 1'b0;
            speed_q <= 1'b0;
            stopband_q <= 1'b0;
            side_src_q <= '{SIDE_NONE, SIDE_NONE};
            hpf_on_q <= HPF_ON_RST;
            corner_q <= 2'h0;
            inv_q <= '{1'b0, 1'b0};
            rec_on_q <= '{1'b0, 1'b0};
            play_on_q <= '{1'b0, 1'b0};
            rec_pend_q <= '{GAIN_RST, GAIN_RST};
            play_pend_q <= '{GAIN_RST, GAIN_RST};
        end else if (reg_wr) begin
            unique case (reg_addr)
                SILENCE_IDX: mute_q <= reg_wdata[MUTE_BIT];
                UNMUTE_CFG_IDX: begin
                    unmute_ramp_q <= reg_wdata[UNMUTE_RAMP_BIT];
                    speed_q <= reg_wdata[RAMP_SPEED_BIT];
                    stopband_q <= reg_wdata[STOPBAND_BIT];
                end
                SIDETONE_IDX: begin
                    side_src_q[0] <= side_src_t'(reg_wdata[SIDE_L_LSB +: 2]);
                    side_src_q[1] <= side_src_t'(reg_wdata[SIDE_R_LSB +: 2]);
                end
                REC_FILT_IDX: begin
                    hpf_on_q <= reg_wdata[HPF_ON_BIT];
                    corner_q <= reg_wdata[CORNER_LSB +: 2];
                    inv_q[0] <= reg_wdata[INV_L_BIT];
                    inv_q[1] <= reg_wdata[INV_R_BIT];
                end
                REC_GAIN_L_IDX: begin
                    rec_on_q[0] <= reg_wdata[CHAN_ON_BIT];
                    rec_pend_q[0] <= reg_wdata[7:0];
                end
                REC_GAIN_R_IDX: begin
                    rec_on_q[1] <= reg_wdata[CHAN_ON_BIT];
                    rec_pend_q[1] <= reg_wdata[7:0];
                end
                PLAY_GAIN_L_IDX: begin
                    play_on_q[0] <= reg_wdata[CHAN_ON_BIT];
                    play_pend_q[0] <= reg_wdata[7:0];
                end
                PLAY_GAIN_R_IDX: begin
                    play_on_q[1] <= reg_wdata[CHAN_ON_BIT];
                    play_pend_q[1] <= reg_wdata[7:0];
                end
                default: ;
            endcase
        end
    end

    // ************************************************************
    // gain commit: both channels move together, one cycle after the write
    // ************************************************************
    logic [7:0] rec_act_q [2];
    logic [7:0] play_act_q [2];

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rec_commit_q <= 1'b0;
            play_commit_q <= 1'b0;
        end else begin
            rec_commit_q <= wr_gain_rec && reg_wdata[COMMIT_BIT];
            play_commit_q <= wr_gain_play && reg_wdata[COMMIT_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rec_act_q <= '{GAIN_RST, GAIN_RST};
            play_act_q <= '{GAIN_RST, GAIN_RST};
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (rec_commit_q) begin
                    // out-of-range codes would scale past the documented top
                    rec_act_q[c] <= (rec_pend_q[c] > REC_GAIN_MAX) ? REC_GAIN_MAX
                        : rec_pend_q[c];
                end
                if (play_commit_q) begin
                    play_act_q[c] <= play_pend_q[c];
                end
            end
        end
    end

    // ************************************************************
    // playback mute ramp, stepped by accepted playback samples
    // ************************************************************
    logic [7:0] play_cur_q [2];
    logic [4:0] ramp_cnt_q;
    logic ramp_tick;
    logic play_push;
    logic [5:0] ramp_div;
    logic [7:0] ramp_tgt [2];

    assign ramp_div = speed_q ? SLOW_DIV : FAST_DIV;
    assign ramp_tick = play_push && ({1'b0, ramp_cnt_q} == ramp_div - 6'h01);
    assign ramp_tgt[0] = mute_q ? 8'h00 : play_act_q[0];
    assign ramp_tgt[1] = mute_q ? 8'h00 : play_act_q[1];

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ramp_cnt_q <= 5'h00;
        end else if (play_push) begin
            ramp_cnt_q <= ramp_tick ? 5'h00 : ramp_cnt_q + 5'h01;
        end
    end

    // mute always fades down; the unmute mode decides how it comes back
    always_ff @(posedge clk) begin
        if (!rstn) begin
            play_cur_q <= '{8'h00, 8'h00};
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (!mute_q && !unmute_ramp_q) begin
                    play_cur_q[c] <= play_act_q[c];
                end else if (ramp_tick && play_cur_q[c] < ramp_tgt[c]) begin
                    play_cur_q[c] <= play_cur_q[c] + 8'h01;
                end else if (ramp_tick && play_cur_q[c] > ramp_tgt[c]) begin
                    play_cur_q[c] <= play_cur_q[c] - 8'h01;
                end
            end
        end
    end

    // ************************************************************
    // record path: high-pass, invert, gain, enable
    // ************************************************************
    acc_t acc1_q [2], acc2_q [2], acc1_d [2], acc2_d [2];
    sample_t rx [2], hp1 [2], hp_out [2], inv_out [2], rec_res [2], rec_last_q [2];
    logic rec_push;
    logic [3:0] hp_k;

    assign rx[0] = rec_in.left;
    assign rx[1] = rec_in.right;
    assign hp_k = HPF_K[corner_q];
    assign rec_push = rec_in_valid && rec_in_ready;

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            acc1_d[c] = hp_next(rx[c], acc1_q[c], hp_k);
            hp1[c] = hp_sub(rx[c], acc1_q[c]);
            acc2_d[c] = acc2_q[c];
            hp_out[c] = hp1[c];
            if (corner_q != 2'h0) begin
                acc2_d[c] = hp_next(hp1[c], acc2_q[c], hp_k);
                hp_out[c] = hp_sub(hp1[c], acc2_q[c]);
            end
            if (!hpf_on_q) begin
                hp_out[c] = rx[c];
            end
            inv_out[c] = inv_q[c] ? sat(-41'(hp_out[c])) : hp_out[c];
            rec_res[c] = rec_on_q[c] ? apply_gain(inv_out[c], rec_act_q[c]) : '0;
        end
    end

    // filter state freezes while bypassed so re-enabling resumes smoothly
    always_ff @(posedge clk) begin
        if (!rstn) begin
            acc1_q <= '{'0, '0};
            acc2_q <= '{'0, '0};
            rec_last_q <= '{'0, '0};
        end else if (rec_push) begin
            rec_last_q <= rec_res;
            if (hpf_on_q) begin
                acc1_q <= acc1_d;
                acc2_q <= acc2_d;
            end
        end
    end

    two_slot_buffer #(.W(2 * SW)) rec_buf (
        .clk(clk),
        .rstn(rstn),
        .in_valid(rec_in_valid),
        .in_ready(rec_in_ready),
        .in_data({rec_res[0], rec_res[1]}),
        .out_valid(rec_out_valid),
        .out_ready(rec_out_ready),
        .out_data(rec_out)
    );

    // ************************************************************
    // playback path: sidetone mix, stopband shape, gain
    // ************************************************************
    sample_t px [2], side [2], mix [2], shaped [2], play_res [2], prev_q [2];

    assign px[0] = play_in.left;
    assign px[1] = play_in.right;
    assign play_push = play_in_valid && play_in_ready;

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            unique case (side_src_q[c])
                SIDE_LEFT: side[c] = rec_last_q[0];
                SIDE_RIGHT: side[c] = rec_last_q[1];
                default: side[c] = '0;
            endcase
            mix[c] = sat(41'(px[c]) + 41'(side[c]));
            // sloping stopband: a two-tap average deepens the top octave
            shaped[c] = stopband_q ? sat((41'(mix[c]) + 41'(prev_q[c])) >>> 1)
                : mix[c];
            play_res[c] = play_on_q[c] ? apply_gain(shaped[c], play_cur_q[c]) : '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            prev_q <= '{'0, '0};
        end else if (play_push) begin
            prev_q <= mix;
        end
    end

    two_slot_buffer #(.W(2 * SW)) play_buf (
        .clk(clk),
        .rstn(rstn),
        .in_valid(play_in_valid),
        .in_ready(play_in_ready),
        .in_data({play_res[0], play_res[1]}),
        .out_valid(play_out_valid),
        .out_ready(play_out_ready),
        .out_data(play_out)
    );

    // ************************************************************
    // read back; commit bits read as zero, bit 0 of the mute word is ramp busy
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= 16'h0000;
            unique case (reg_addr)
                SILENCE_IDX: begin
                    reg_rdata[MUTE_BIT] <= mute_q;
                    reg_rdata[RAMP_BUSY_BIT] <= (play_cur_q[0] != ramp_tgt[0])
                        || (play_cur_q[1] != ramp_tgt[1]);
                end
                UNMUTE_CFG_IDX: begin
                    reg_rdata[UNMUTE_RAMP_BIT] <= unmute_ramp_q;
                    reg_rdata[RAMP_SPEED_BIT] <= speed_q;
                    reg_rdata[STOPBAND_BIT] <= stopband_q;
                end
                SIDETONE_IDX: begin
                    reg_rdata[SIDE_L_LSB +: 2] <= side_src_q[0];
                    reg_rdata[SIDE_R_LSB +: 2] <= side_src_q[1];
                end
                REC_FILT_IDX: begin
                    reg_rdata[HPF_ON_BIT] <= hpf_on_q;
                    reg_rdata[CORNER_LSB +: 2] <= corner_q;
                    reg_rdata[INV_L_BIT] <= inv_q[0];
                    reg_rdata[INV_R_BIT] <= inv_q[1];
                end
                REC_GAIN_L_IDX: reg_rdata <= {rec_on_q[0], 7'h00, rec_pend_q[0]};
                REC_GAIN_R_IDX: reg_rdata <= {rec_on_q[1], 7'h00, rec_pend_q[1]};
                PLAY_GAIN_L_IDX: reg_rdata <= {play_on_q[0], 7'h00, play_pend_q[0]};
                PLAY_GAIN_R_IDX: reg_rdata <= {play_on_q[1], 7'h00, play_pend_q[1]};
                default: ;
            endcase
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_mute_after_reset: assert property (
        @(posedge clk) disable iff (!rstn) $rose(rstn) |-> mute_q && play_cur_q[0] == 8'h00)
        else $error("playback not muted after reset");
    a_jump_unmute: assert property (
        @(posedge clk) disable iff (!rstn)
        (!mute_q && !unmute_ramp_q) |=> play_cur_q[0] == $past(play_act_q[0]))
        else $error("immediate unmute did not reach gain");
    a_ramp_single_step: assert property (
        @(posedge clk) disable iff (!rstn) (mute_q || unmute_ramp_q) |=>
        (play_cur_q[1] == $past(play_cur_q[1]) || play_cur_q[1] == $past(play_cur_q[1]) + 8'h01
        || play_cur_q[1] == $past(play_cur_q[1]) - 8'h01))
        else $error("ramp moved more than one step");
    a_ramp_only_tick: assert property (
        @(posedge clk) disable iff (!rstn)
        ((mute_q || unmute_ramp_q) && !ramp_tick) |=> $stable(play_cur_q[0]))
        else $error("ramp moved off its tick");
    a_sidetone_none: assert property (
        @(posedge clk) disable iff (!rstn)
        (play_push && side_src_q[0] == SIDE_NONE) |-> mix[0] == play_in.left)
        else $error("sidetone mixed while off");
    a_hpf_bypass: assert property (
        @(posedge clk) disable iff (!rstn) (rec_push && !hpf_on_q) |-> hp_out[1] == rec_in.right)
        else $error("high-pass not bypassed");
    a_rec_disabled: assert property (
        @(posedge clk) disable iff (!rstn) (rec_push && !rec_on_q[0]) |=> rec_last_q[0] == '0)
        else $error("disabled record channel produced data");
    a_rec_commit: assert property (
        @(posedge clk) disable iff (!rstn) (wr_gain_rec && reg_wdata[COMMIT_BIT]) |=> ##1
        (rec_act_q[0] <= REC_GAIN_MAX && rec_act_q[1] <= REC_GAIN_MAX))
        else $error("record commit out of range");
    a_rec_hold: assert property (
        @(posedge clk) disable iff (!rstn) !rec_commit_q |=> $stable(rec_act_q[0]))
        else $error("record gain moved without commit");
    a_play_hold: assert property (
        @(posedge clk) disable iff (!rstn) !play_commit_q |=> $stable(play_act_q[1]))
        else $error("playback gain moved without commit");
endmodule : audio_gain_path

// ---- audio_path_pkg.sv ----
// constants, types and helper functions of the audio gain and filter path
package audio_path_pkg;
    localparam int SW = 16;
    localparam int ACC_W = SW + 12;
    typedef logic signed [SW-1:0] sample_t;
    typedef logic signed [ACC_W-1:0] acc_t;
    typedef struct packed {sample_t left; sample_t right;} stereo_t;
    typedef enum logic [1:0] {
        SIDE_NONE = 2'b00, SIDE_LEFT = 2'b01, SIDE_RIGHT = 2'b10, SIDE_UNUSED = 2'b11
    } side_src_t;
    // register indices as printed
    localparam logic [7:0] PLAY_GAIN_L_IDX = 8'h32;
    localparam logic [7:0] PLAY_GAIN_R_IDX = 8'h33;
    localparam logic [7:0] SILENCE_IDX = 8'h3A;
    localparam logic [7:0] UNMUTE_CFG_IDX = 8'h3B;
    localparam logic [7:0] SIDETONE_IDX = 8'h3C;
    localparam logic [7:0] REC_FILT_IDX = 8'h40;
    localparam logic [7:0] REC_GAIN_L_IDX = 8'h42;
    localparam logic [7:0] REC_GAIN_R_IDX = 8'h43;
    // field positions
    localparam int MUTE_BIT = 14;
    localparam int RAMP_BUSY_BIT = 0;
    localparam int UNMUTE_RAMP_BIT = 14;
    localparam int RAMP_SPEED_BIT = 13;
    localparam int STOPBAND_BIT = 12;
    localparam int SIDE_L_LSB = 12;
    localparam int SIDE_R_LSB = 10;
    localparam int HPF_ON_BIT = 15;
    localparam int CORNER_LSB = 8;
    localparam int INV_L_BIT = 1;
    localparam int INV_R_BIT = 0;
    localparam int CHAN_ON_BIT = 15;
    localparam int COMMIT_BIT = 8;
    // reset values
    localparam logic MUTE_RST = 1'b1;
    localparam logic HPF_ON_RST = 1'b1;
    localparam logic [7:0] GAIN_RST = 8'hC0;
    localparam logic [7:0] GAIN_UNITY = 8'hC0;
    localparam logic [7:0] REC_GAIN_MAX = 8'hEF;
    // ramp stepping relative to the sample rate
    localparam int FS_HZ = 48000;
    localparam int FAST_STEP_HZ = 24000;
    localparam int SLOW_STEP_HZ = 1500;
    localparam logic [5:0] FAST_DIV = 6'(FS_HZ / FAST_STEP_HZ);
    localparam logic [5:0] SLOW_DIV = 6'(FS_HZ / SLOW_STEP_HZ);
    // high-pass shifts for 2^-11, 2^-5, 2^-4, 2^-3
    localparam int HPF_FRAC = 11;
    localparam logic [3:0] HPF_K [4] = '{4'hB, 4'h5, 4'h4, 4'h3};
    localparam sample_t S_MAX = 16'sh7FFF;
    localparam sample_t S_MIN = 16'sh8000;
    // 2^(k/16) in Q1.15: sixteen codes of 0.375 dB make one 6 dB octave
    localparam logic [16:0] GAIN_MANT [16] = '{
        17'h08000, 17'h085AB, 17'h08B96, 17'h091C4, 17'h09838, 17'h09EF5, 17'h0A5FF,
        17'h0AD58, 17'h0B505, 17'h0BD09, 17'h0C567, 17'h0CE25, 17'h0D745, 17'h0E0CD,
        17'h0EAC1, 17'h0F525};

    function automatic sample_t sat(input logic signed [40:0] v);
        if (v > 41'(S_MAX)) return S_MAX;
        if (v < 41'(S_MIN)) return S_MIN;
        return sample_t'(v);
    endfunction : sat

    function automatic sample_t apply_gain(input sample_t x, input logic [7:0] code);
        logic signed [8:0] e;
        logic [4:0] sh;
        logic signed [40:0] p;
        e = $signed({1'b0, code}) - $signed({1'b0, GAIN_UNITY});
        sh = 5'(5'sd15 - $signed(e[8:4]));
        p = 41'(x) * 41'($signed({1'b0, GAIN_MANT[e[3:0]]}));
        if (code == 8'h00) return '0;
        return sat(p >>> sh);
    endfunction : apply_gain

    function automatic acc_t hp_next(input sample_t x, input acc_t acc, input logic [3:0] k);
        return acc + (((ACC_W'(x)) <<< HPF_FRAC) - acc >>> k);
    endfunction : hp_next

    function automatic sample_t hp_sub(input sample_t x, input acc_t acc);
        return sat(41'(x) - 41'(acc >>> HPF_FRAC));
    endfunction : hp_sub
endpackage : audio_path_pkg

// ---- two_slot_buffer.sv ----
// two-entry buffer with valid and ready on both sides, all outputs registered
`timescale 1ns/1ps
module two_slot_buffer #(
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic skid_v_q;
    logic [W-1:0] skid_q;
    logic push;
    logic drain;
    assign push = in_valid && in_ready;
    assign drain = out_ready || !out_valid;

    // in_ready is its own flop so the source sees a registered stall
    always_ff @(posedge clk) begin
        if (!rstn) begin
            out_valid <= 1'b0;
            out_data <= '0;
            skid_v_q <= 1'b0;
            skid_q <= '0;
            in_ready <= 1'b1;
        end else if (drain) begin
            if (skid_v_q) begin
                out_data <= skid_q;
                out_valid <= 1'b1;
                skid_v_q <= 1'b0;
                in_ready <= 1'b1;
            end else begin
                out_valid <= push;
                if (push) begin
                    out_data <= in_data;
                end
            end
        end else if (push) begin
            skid_q <= in_data;
            skid_v_q <= 1'b1;
            in_ready <= 1'b0;
        end
    end
endmodule : two_slot_buffer

// ---- test_audio_gain_path.sv ----
// self-checking bench for the record and playback gain path
`timescale 1ns/1ps
module test_audio_gain_path;
    import audio_path_pkg::*;
    logic clk, rstn, reg_wr, reg_rd, riv, rir, rov, ror, piv, pir, pov, por;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, q16;
    stereo_t ri, ro, pi, po;
    logic [31:0] q;
    int fails, checks, n, acc;
    logic tk;
    logic [15:0] st [3] = '{16'h1800, 16'h2400, 16'h3C00};
    logic [31:0] sx [3] = '{32'h0100_0200, 32'h0200_0100, 32'h0};
    audio_gain_path audio_gain_path_i (.clk(clk), .rstn(rstn), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .rec_in(ri), .rec_in_valid(riv), .rec_in_ready(rir), .rec_out(ro),
        .rec_out_valid(rov), .rec_out_ready(ror), .play_in(pi), .play_in_valid(piv),
        .play_in_ready(pir), .play_out(po), .play_out_valid(pov), .play_out_ready(por));
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    // ****************************************
    // bus and stream tasks
    // ****************************************
    task end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim
    task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task tmo;
        // a stuck handshake ends the run rather than hanging it
        if (n >= 40) begin
            fails++;
            end_sim;
        end
    endtask : tmo
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd
    task push(input logic p, input logic [31:0] d);
        @(posedge clk);
        if (p) begin
            pi <= d;
            piv <= 1'b1;
        end else begin
            ri <= d;
            riv <= 1'b1;
        end
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((p ? pir : rir) !== 1'b1 && n < 40);
        tmo;
        @(posedge clk);
        piv <= 1'b0;
        riv <= 1'b0;
    endtask : push
    task pull(input logic p, output logic [31:0] d);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((p ? pov : rov) !== 1'b1 && n < 40);
        tmo;
        d = p ? po : ro;
    endtask : pull
    task xf(input string nm, input logic p, input logic [31:0] d, input logic [31:0] e);
        push(p, d);
        pull(p, q);
        cmp(nm, e, q);
    endtask : xf
    task ramp(input int cnt, input logic up);
        logic [31:0] pv;
        logic ok;
        for (int i = 0; i < cnt; i++) begin
            pv = q;
            push(1'b1, 32'h1000_2000);
            pull(1'b1, q);
            ok = up ? (q[31:16] >= pv[31:16]) : (q[31:16] <= pv[31:16]);
            if (i > 0) cmp("ramp_dir", 32'h1, 32'(ok));
        end
    endtask : ramp
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {rstn, reg_wr, reg_rd, riv, piv, reg_addr, reg_wdata, ri, pi} = '0;
        {ror, por, fails, checks} = {2'b11, 64'd0};
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rd(8'h3A, q16);
        cmp("mute_rst", 32'h4000, q16 & 16'h4000);
        rd(8'h40, q16);
        cmp("hpf_rst", 32'h8000, q16 & 16'h8000);
        rd(8'h42, q16);
        cmp("gain_rst", 32'h00C0, q16);
        rd(8'h55, q16);
        cmp("unmapped", 32'h0, q16);
        xf("rec_off", 1'b0, 32'h0100_0200, 32'h0);
        wr(8'h40, 16'h0000);
        wr(8'h43, 16'h80C0);
        wr(8'h42, 16'h81C0);
        rd(8'h42, q16);
        cmp("commit_rd", 32'h80C0, q16);
        xf("rec_unity", 1'b0, 32'h0100_0200, 32'h0100_0200);
        wr(8'h40, 16'h0002);
        xf("rec_inv", 1'b0, 32'h0100_0200, 32'hFF00_0200);
        wr(8'h40, 16'h0000);
        wr(8'h42, 16'h80D0);
        xf("rec_pend", 1'b0, 32'h0100_0200, 32'h0100_0200);
        wr(8'h43, 16'h81D0);
        xf("rec_6db", 1'b0, 32'h0100_0200, 32'h0200_0400);
        wr(8'h42, 16'h80FF);
        wr(8'h43, 16'h81EF);
        xf("rec_clamp", 1'b0, 32'h0100_0100, 32'h07A9_07A9);
        wr(8'h43, 16'h80C0);
        wr(8'h42, 16'h8100);
        xf("rec_zero", 1'b0, 32'h0100_0200, 32'h0000_0200);
        wr(8'h42, 16'h81C0);
        xf("rec_last", 1'b0, 32'h0100_0200, 32'h0100_0200);
        xf("play_muted", 1'b1, 32'h1000_2000, 32'h0);
        wr(8'h32, 16'h80C0);
        wr(8'h33, 16'h81C0);
        wr(8'h3A, 16'h0000);
        xf("play_jump", 1'b1, 32'h1000_2000, 32'h1000_2000);
        for (int i = 0; i < 3; i++) begin
            wr(8'h3C, st[i]);
            xf("sidetone", 1'b1, 32'h0, sx[i]);
        end
        wr(8'h3C, 16'h0000);
        wr(8'h3B, 16'h1000);
        xf("stopband", 1'b1, 32'h1000_2000, 32'h0800_1000);
        wr(8'h3B, 16'h4000);
        wr(8'h3A, 16'h4000);
        // ramp ticks follow accepted samples, so the mute needs traffic to fall
        ramp(400, 1'b0);
        cmp("ramp_down", 32'h0, q);
        wr(8'h3A, 16'h0000);
        ramp(2, 1'b1);
        cmp("ramp_step", 32'h1, q[31:16] < 16'h1000);
        ramp(400, 1'b1);
        cmp("ramp_top", 32'h1000_2000, q);
        // slow rate: forty samples move the gain by one code at most
        wr(8'h3B, 16'h6000);
        wr(8'h3A, 16'h4000);
        ramp(40, 1'b0);
        cmp("ramp_slow", 32'h1, q[31:16] >= 16'h0E00);
        // a constant input must decay through the second-order high-pass
        wr(8'h40, 16'h8300);
        repeat (60) begin
            push(1'b0, 32'h0100_0100);
            pull(1'b0, q);
        end
        cmp("hpf_dc", 32'h1, 32'(q[31:16] + 16'h0010 < 16'h0020));
        wr(8'h40, 16'h0000);
        @(posedge clk);
        ror <= 1'b0;
        riv <= 1'b1;
        ri <= '0;
        acc = 0;
        repeat (8) begin
            @(negedge clk);
            tk = rir;
            @(posedge clk);
            if (tk) begin
                acc++;
                ri <= {16'(acc), 16'(acc)};
            end
        end
        riv <= 1'b0;
        ror <= 1'b1;
        cmp("refused", 32'd2, acc);
        for (int j = 0; j < acc; j++) begin
            pull(1'b0, q);
            cmp("drain", {16'(j), 16'(j)}, q);
        end
        end_sim;
    end
endmodule : test_audio_gain_path
